// File: rtl/ssp_cfg.svh
// Purpose: Sizes, byte enable patterns, reset values and timing counts of the burst SRAM port.
// Assumes: Included by the package and by every design file.
// Notes: Definitions only.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_ADDR_W 19
`define SSP_LANES 4
`define SSP_LANE_DW 8
`define SSP_CNT_W 2
`define SSP_CNT_START 2'h0
`define SSP_CNT_ONE 2'h1
`define SSP_BE_ALL 4'hf
`define SSP_BE_NONE 4'h0
`define SSP_ORDER_RST 1'h1
`define SSP_PERIOD_NS 10
`define SSP_RD_LAT_CYC 1
`endif

// File: rtl/ssp_pkg.sv
// Purpose: Types shared by the burst SRAM port and its leaf modules.
// Assumes: Sizes come from the cfg header.
// Notes: Lanes are packed with lane 0 in the low bits.
package ssp_pkg;
  `include "ssp_cfg.svh"

  // One byte lane: parity bit above eight data bits
  typedef struct packed {
    logic parity_lane;
    logic [`SSP_LANE_DW-1:0] data_lane;
  } ssp_lane_t;

  typedef ssp_lane_t [`SSP_LANES-1:0] ssp_bus_t;

  // Synchronous control pins sampled every rising edge
  typedef struct packed {
    logic chip_sel_a_n;
    logic chip_sel_b;
    logic chip_sel_c_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic all_bytes_write_n;
    logic lane_write_en_n;
    logic [`SSP_LANES-1:0] lane_sel_n;
  } ssp_ctl_t;

  typedef enum logic [1:0] {
    SSP_ST_DESEL,
    SSP_ST_ACTIVE,
    SSP_ST_SLEEP
  } ssp_st_t;
endpackage : ssp_pkg

// File: rtl/ssp_mem.sv
// Purpose: Storage array of the port, one array per byte lane.
// Assumes: One access per clock; read data leave a register.
// Notes: A write returns its own new data on the same edge (pass-through).
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module ssp_mem (
  // Clock
  input wire logic core_clk_i,
  // Access
  input wire logic we_i,
  input wire logic [`SSP_LANES-1:0] be_i,
  input wire logic [`SSP_ADDR_W-1:0] addr_i,
  input wire ssp_pkg::ssp_bus_t wdata_i,
  output ssp_pkg::ssp_bus_t rdata_o
);
  import ssp_pkg::*;

  // Per-lane array with byte write and registered read
  for (genvar g = 0; g < `SSP_LANES; g++) begin : g_lane
    ssp_lane_t mem_r [0:(1<<`SSP_ADDR_W)-1];
    always_ff @(posedge core_clk_i) begin
      if (we_i && be_i[g]) begin
        mem_r[addr_i] <= wdata_i[g];
        rdata_o[g] <= wdata_i[g]; // Pass-through
      end else begin
        rdata_o[g] <= mem_r[addr_i];
      end
    end
  end
endmodule : ssp_mem

// File: rtl/ssp_burst_ctr.sv
// Purpose: Two-bit wraparound burst counter, linear or interleaved order.
// Assumes: Load has priority over step.
// Notes: The next value is also given out so the array can be read at once.
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module ssp_burst_ctr (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic load_i,
  input wire logic [`SSP_CNT_W-1:0] start_i,
  input wire logic step_i,
  input wire logic interleave_i,
  // Burst address bits
  output logic [`SSP_CNT_W-1:0] low_o,
  output logic [`SSP_CNT_W-1:0] low_nxt_o
);
  logic [`SSP_CNT_W-1:0] start_r;
  logic [`SSP_CNT_W-1:0] ofs_r;
  logic [`SSP_CNT_W-1:0] ofs_nxt;

  // Sequence position and order mapping
  always_comb begin
    ofs_nxt = load_i ? `SSP_CNT_START : (step_i ? ofs_r + `SSP_CNT_ONE : ofs_r);
    if (load_i) begin
      low_nxt_o = start_i;
    end else if (interleave_i) begin
      low_nxt_o = start_r ^ ofs_nxt;
    end else begin
      low_nxt_o = start_r + ofs_nxt;
    end
  end

  // Counter state
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      start_r <= `SSP_CNT_START;
      ofs_r <= `SSP_CNT_START;
      low_o <= `SSP_CNT_START;
    end else begin
      if (load_i) begin
        start_r <= start_i;
      end
      ofs_r <= ofs_nxt;
      low_o <= low_nxt_o;
    end
  end
endmodule : ssp_burst_ctr

// File: rtl/ssp_port.sv
// Purpose: Synchronous flow-through burst SRAM port: selects, strobes, burst, data lanes.
// Assumes: Address, control and data inputs synchronous to core_clk_i; test clock sampled as a plain input.
// Notes: Data pins are split into input, output and one output enable.
`timescale 1ns/100ps
`include "ssp_cfg.svh"

// Function
// - First chip select is active low, sampled each rising edge.
// - Processor strobe ignored while the first chip select is high.
// - Second chip select is active high, sampled each rising edge.
// - Third chip select is active low, sampled each rising edge.
// - Data pins driven while output enable is low, released while high.
// - First read clock after deselect never drives the data pins.
// - Burst step low during a burst advances the burst address.
// - Processor strobe captures the address and loads the counter.
// - Controller strobe captures the address and loads the counter.
// - With both strobes low and the first chip select low, only the processor strobe acts.
// - Order strap: low is linear, high is interleaved; held static.
// - Sleep request stops activity and keeps the array contents.
// - Data pins acting as inputs are captured on the rising edge.
// - Read output shows the location addressed at the previous edge.
// - Data bus is byte lanes of eight data bits and one parity bit.
// - Scan serial output changes on the test clock falling edge.
// - Scan serial input is sampled on the test clock rising edge.
// - Two-bit wrap counter: plus one, or start XOR step count.
// - A detected write releases the data pins regardless of output enable.
// - Global write low writes every byte lane.
module ssp_port (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Address and synchronous controls
  input wire logic [`SSP_ADDR_W-1:0] addr_i,
  input wire ssp_pkg::ssp_ctl_t ctl_i,
  // Asynchronous controls and strap
  input wire logic out_en_n_i,
  input wire logic sleep_req_i,
  input wire logic burst_order_i,
  // Data lanes
  input wire ssp_pkg::ssp_bus_t dq_i,
  output ssp_pkg::ssp_bus_t dq_o,
  output logic dq_oe_o,
  // Boundary scan serial path
  input wire logic tck_i,
  input wire logic tdi_i,
  output logic tdo_o
);
  import ssp_pkg::*;

  ssp_st_t st_r;
  ssp_st_t st_nxt;
  logic order_r;
  logic rd_r;
  logic mask_r;
  logic wr_r;
  logic [`SSP_ADDR_W-1:0] hi_r;
  logic [`SSP_CNT_W-1:0] low_r;
  logic [`SSP_CNT_W-1:0] low_nxt;
  logic [`SSP_ADDR_W-1:0] addr_r;
  logic [`SSP_ADDR_W-1:0] addr_nxt;
  logic sel;
  logic proc_go;
  logic ctrl_go;
  logic start_sel;
  logic desel;
  logic cont;
  logic step;
  logic wr_req;
  logic we;
  logic [`SSP_LANES-1:0] be;
  logic tck_q;
  logic scan_r;

  // Chip selection from all three selects
  assign sel = !ctl_i.chip_sel_a_n
    && ctl_i.chip_sel_b
    && !ctl_i.chip_sel_c_n;

  // Strobe qualification and priority
  assign proc_go = !ctl_i.proc_addr_strobe_n && !ctl_i.chip_sel_a_n && !sleep_req_i;
  assign ctrl_go = !ctl_i.ctrl_addr_strobe_n && !proc_go && !sleep_req_i;
  assign start_sel = (proc_go || ctrl_go) && sel;
  assign desel = (proc_go || ctrl_go) && !sel;
  assign cont = !proc_go && !ctrl_go && !sleep_req_i && st_r == SSP_ST_ACTIVE;
  assign step = cont && !ctl_i.burst_step_n;

  // Write request and byte lane enables
  always_comb begin
    wr_req = !ctl_i.all_bytes_write_n
      || (!ctl_i.lane_write_en_n && !(&ctl_i.lane_sel_n));
    if (!ctl_i.all_bytes_write_n) begin
      be = `SSP_BE_ALL;
    end else if (!ctl_i.lane_write_en_n) begin
      be = ~ctl_i.lane_sel_n;
    end else begin
      be = `SSP_BE_NONE;
    end
  end

  // Processor-strobe start ignores writes in its first clock
  assign we = (ctrl_go && sel && wr_req) || (cont && wr_req);

  // Burst counter for the two low address bits
  ssp_burst_ctr u_ctr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(start_sel),
    .start_i(addr_i[`SSP_CNT_W-1:0]),
    .step_i(step),
    .interleave_i(order_r),
    .low_o(low_r),
    .low_nxt_o(low_nxt)
  );

  // Current and next word address
  assign addr_r = {hi_r[`SSP_ADDR_W-1:`SSP_CNT_W], low_r};
  assign addr_nxt = start_sel ? addr_i
    : {hi_r[`SSP_ADDR_W-1:`SSP_CNT_W], low_nxt};

  // Upper address bits change only on a taken strobe
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hi_r <= '0;
    end else if (start_sel) begin
      hi_r <= addr_i;
    end
  end

  // Order strap caught during reset, then held
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      order_r <= burst_order_i;
    end
  end

  // Selection state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SSP_ST_DESEL, SSP_ST_ACTIVE: begin
        if (sleep_req_i) begin
          st_nxt = SSP_ST_SLEEP;
        end else if (start_sel) begin
          st_nxt = SSP_ST_ACTIVE;
        end else if (desel) begin
          st_nxt = SSP_ST_DESEL;
        end
      end
      SSP_ST_SLEEP: begin
        if (!sleep_req_i) begin
          st_nxt = SSP_ST_DESEL;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_r <= SSP_ST_DESEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Cycle kind of the clock now under way
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      mask_r <= 1'b0;
    end else begin
      rd_r <= (start_sel || cont) && !we;
      wr_r <= we;
      mask_r <= start_sel && !we && st_r != SSP_ST_ACTIVE;
    end
  end

  // Storage; read data are registered for the next clock
  ssp_mem u_mem (
    .core_clk_i(core_clk_i),
    .we_i(we && !sleep_req_i),
    .be_i(be),
    .addr_i(addr_nxt),
    .wdata_i(dq_i),
    .rdata_o(dq_o)
  );

  // Output drive: read, unmasked, no write seen, not asleep
  assign dq_oe_o = !out_en_n_i
    && rd_r
    && !mask_r
    && !(st_r == SSP_ST_ACTIVE && wr_req)
    && !sleep_req_i;

  // One-bit scan path clocked by core_clk_i, acting on detected test clock edges
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tck_q <= 1'b0;
      scan_r <= 1'b0;
      tdo_o <= 1'b0;
    end else begin
      tck_q <= tck_i;
      if (tck_i && !tck_q) begin
        scan_r <= tdi_i;
      end
      if (!tck_i && tck_q) begin
        tdo_o <= scan_r;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_desel_a;
    !sleep_req_i && !ctl_i.ctrl_addr_strobe_n && ctl_i.chip_sel_a_n
    |=> st_r == SSP_ST_DESEL;
  endproperty
  a_desel_a: assert property (p_desel_a) else $error("first select high did not deselect");

  property p_proc_ignored;
    st_r == SSP_ST_ACTIVE && !sleep_req_i && ctl_i.chip_sel_a_n
    && !ctl_i.proc_addr_strobe_n && ctl_i.ctrl_addr_strobe_n && ctl_i.burst_step_n
    |=> $stable(addr_r);
  endproperty
  a_proc_ignored: assert property (p_proc_ignored) else $error("ignored strobe moved address");

  property p_desel_b;
    !sleep_req_i && !ctl_i.ctrl_addr_strobe_n && !ctl_i.chip_sel_b
    |=> st_r == SSP_ST_DESEL;
  endproperty
  a_desel_b: assert property (p_desel_b) else $error("second select low did not deselect");

  property p_desel_c;
    !sleep_req_i && !ctl_i.ctrl_addr_strobe_n && ctl_i.chip_sel_c_n
    |=> st_r == SSP_ST_DESEL;
  endproperty
  a_desel_c: assert property (p_desel_c) else $error("third select high did not deselect");

  property p_oe_off;
    out_en_n_i |-> !dq_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pins driven with output enable high");

  property p_first_mask;
    st_r == SSP_ST_DESEL && start_sel && !we |=> !dq_oe_o;
  endproperty
  a_first_mask: assert property (p_first_mask) else $error("first read clock drove pins");

  property p_step;
    step |=> low_r != $past(low_r);
  endproperty
  a_step: assert property (p_step) else $error("burst step did not advance");

  property p_proc_cap;
    proc_go && sel |=> addr_r == $past(addr_i);
  endproperty
  a_proc_cap: assert property (p_proc_cap) else $error("processor strobe missed address");

  property p_ctrl_cap;
    ctrl_go && sel |=> addr_r == $past(addr_i);
  endproperty
  a_ctrl_cap: assert property (p_ctrl_cap) else $error("controller strobe missed address");

  property p_both;
    !ctl_i.proc_addr_strobe_n && !ctl_i.ctrl_addr_strobe_n && !ctl_i.chip_sel_a_n
    && !sleep_req_i |-> !we;
  endproperty
  a_both: assert property (p_both) else $error("controller strobe acted beside processor");

  property p_strap;
    ##1 $stable(order_r);
  endproperty
  a_strap: assert property (p_strap) else $error("order strap changed after reset");

  property p_sleep;
    sleep_req_i |-> !dq_oe_o ##1 st_r == SSP_ST_SLEEP && !wr_r;
  endproperty
  a_sleep: assert property (p_sleep) else $error("activity during sleep");

  property p_wdata;
    we && !sleep_req_i && be[0] |=> dq_o[0] == $past(dq_i[0]);
  endproperty
  a_wdata: assert property (p_wdata) else $error("pin data not captured on write");

  property p_linear;
    step && !order_r |=> low_r == $past(low_r) + `SSP_CNT_ONE;
  endproperty
  a_linear: assert property (p_linear) else $error("linear order step wrong");

  property p_wr_hiz;
    wr_r |-> !dq_oe_o;
  endproperty
  a_wr_hiz: assert property (p_wr_hiz) else $error("pins driven in write cycle");

  property p_all_bytes;
    we && !ctl_i.all_bytes_write_n |-> be == `SSP_BE_ALL;
  endproperty
  a_all_bytes: assert property (p_all_bytes) else $error("global write missed a lane");

  property p_high_keep;
    step |=> addr_r[`SSP_ADDR_W-1:`SSP_CNT_W] == $past(addr_r[`SSP_ADDR_W-1:`SSP_CNT_W]);
  endproperty
  a_high_keep: assert property (p_high_keep) else $error("burst moved upper address");

  property p_tdo;
    tck_i || !tck_q |=> $stable(tdo_o);
  endproperty
  a_tdo: assert property (p_tdo) else $error("scan output moved off falling edge");

  property p_wr_pins;
    st_r == SSP_ST_ACTIVE && wr_req |-> !dq_oe_o;
  endproperty
  a_wr_pins: assert property (p_wr_pins) else $error("pins driven while write pins active");

  property p_tdi;
    tck_i && !tck_q |=> scan_r == $past(tdi_i);
  endproperty
  a_tdi: assert property (p_tdi) else $error("scan input not taken on rising edge");

  property p_tdi_hold;
    !(tck_i && !tck_q) |=> $stable(scan_r);
  endproperty
  a_tdi_hold: assert property (p_tdi_hold) else $error("scan input taken off rising edge");

  property p_no_step;
    cont && ctl_i.burst_step_n |=> $stable(low_r);
  endproperty
  a_no_step: assert property (p_no_step) else $error("burst moved without step");

  property p_wake;
    st_r == SSP_ST_SLEEP && !sleep_req_i |=> st_r == SSP_ST_DESEL;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep exit not deselected");

  property p_proc_first;
    proc_go && sel |-> !we;
  endproperty
  a_proc_first: assert property (p_proc_first) else $error("write in first processor clock");

  // Main scenarios
  c_read: cover property (start_sel && !we ##1 rd_r ##1 dq_oe_o);
  c_write: cover property (ctrl_go && sel && wr_req);
  c_burst: cover property (step ##1 step ##1 step);
  c_sleep: cover property (st_r == SSP_ST_ACTIVE ##1 st_r == SSP_ST_SLEEP);
  c_proc_write: cover property (proc_go && sel ##1 cont && wr_req);
endmodule : ssp_port

// File: testbench/ssp_host_bus.sv
// Purpose: Host side of the shared data pins of the burst SRAM port.
// Assumes: The host drives the pins only in its own write cycles.
// Notes: An undriven wire shows the inverse of its last level.
`timescale 1ns/100ps
module ssp_host_bus (
  // Clock
  input wire logic core_clk_i,
  // Port side
  input wire ssp_pkg::ssp_bus_t port_q_i,
  input wire logic port_oe_i,
  // Host side
  input wire ssp_pkg::ssp_bus_t host_d_i,
  input wire logic host_oe_i,
  // Wire level
  output ssp_pkg::ssp_bus_t pin_o
);
  import ssp_pkg::*;
  ssp_bus_t last_r = '0;
  // Resolve the wire from both drivers
  always_comb begin
    pin_o = ~last_r;
    if (host_oe_i) pin_o = host_d_i;
    if (port_oe_i) pin_o = port_q_i;
  end
  // Keep the last level so a floating wire keeps changing
  always_ff @(posedge core_clk_i) begin
    last_r <= pin_o;
  end
endmodule : ssp_host_bus

// File: testbench/test_ssp_port.sv
// Purpose: Self-checking bench of the burst SRAM port.
// Assumes: Controls change by non-blocking assignment on the rising edge.
// Notes: After each cycle call the outputs show the previous call.
`timescale 1ns/100ps
module test_ssp_port;
  import ssp_pkg::*;
  localparam logic [3:0] IDLE = 4'hf, PR = 4'h7, CR = 4'hb, CW = 4'ha;
  localparam logic [3:0] SW = 4'hc, ST = 4'hd, BOTH = 4'h2;
  logic core_clk_i, rst_n_i = 1'h0, out_en_n_i = 1'h0, sleep_req_i = 1'h0;
  logic burst_order_i = 1'h1, tck_i = 1'h0, tdi_i = 1'h0, hoe = 1'h0;
  logic dq_oe_o, tdo_o;
  logic [18:0] addr_i = 19'h0;
  ssp_ctl_t ctl_i = {3'h2, 4'hf, 5'h1f};
  ssp_bus_t dq_i, dq_o, hd = '0;
  logic [2:0] cs = 3'h2;
  logic [4:0] lw = 5'h1f;
  logic [16:0] bh = 17'h15a5a;
  logic [1:0] st = 2'h1;
  int error_cnt = 0, checks = 0;
  ssp_port i_ssp_port (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .ctl_i(ctl_i), .out_en_n_i(out_en_n_i), .sleep_req_i(sleep_req_i),
    .burst_order_i(burst_order_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .tck_i(tck_i), .tdi_i(tdi_i), .tdo_o(tdo_o));
  ssp_host_bus i_ssp_host_bus (.core_clk_i(core_clk_i), .port_q_i(dq_o),
    .port_oe_i(dq_oe_o), .host_d_i(hd), .host_oe_i(hoe), .pin_o(dq_i));
  // Clock
  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Burst address expected at step i
  function automatic logic [18:0] sa(input logic [1:0] i);
    return {bh, burst_order_i ? st ^ i : st + i};
  endfunction : sa
  function automatic ssp_bus_t pat(input logic [18:0] a);
    return ssp_bus_t'({a[17:0], ~a[17:0]});
  endfunction : pat
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // One bus cycle; m holds proc, ctrl, step and global write, all low active
  task automatic cy(input logic [3:0] m, input logic [18:0] a, input ssp_bus_t d);
    @(posedge core_clk_i);
    ctl_i <= {cs, m, lw};
    addr_i <= a;
    hd <= d;
    hoe <= ~(m[0] & lw[4]);
    @(negedge core_clk_i);
  endtask : cy
  task automatic t_reset(input logic o);
    @(posedge core_clk_i);
    rst_n_i <= 1'h0;
    burst_order_i <= o;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    #1;
    chk("rst_oe", 36'(dq_oe_o), 36'h0);
    chk("rst_tdo", 36'(tdo_o), 36'h0);
  endtask : t_reset
  task automatic t_burst;
    cy(CW, sa(0), pat(sa(0)));
    for (int i = 1; i < 4; i++) cy(SW, 19'h0, pat(sa(2'(i))));
    chk("wr_oe", 36'(dq_oe_o), 36'h0);
    cs = 3'h0;
    cy(CR, 19'h0, '0);
    cs = 3'h2;
    cy(PR, {bh, st}, '0);
    cy(ST, 19'h0, '0);
    chk("rd0", dq_o, pat(sa(0)));
    chk("rd0_oe", 36'(dq_oe_o), 36'h0);
    cy(ST, 19'h0, '0);
    chk("rd1", dq_o, pat(sa(1)));
    chk("rd1_oe", 36'(dq_oe_o), 36'h1);
    cy(ST, 19'h0, '0);
    chk("rd2", dq_o, pat(sa(2)));
    cy(IDLE, 19'h0, '0);
    chk("rd3", dq_o, pat(sa(3)));
  endtask : t_burst
  task automatic t_ign;
    cs = 3'h6;
    cy(PR, {~bh, 2'h0}, '0);
    cs = 3'h2;
    cy(IDLE, 19'h0, '0);
    chk("ign", dq_o, pat(sa(3)));
  endtask : t_ign
  task automatic t_both;
    cy(BOTH, sa(0), ~pat(sa(0)));
    cy(IDLE, 19'h0, '0);
    chk("both", dq_o, pat(sa(0)));
  endtask : t_both
  task automatic t_csc;
    cs = 3'h3;
    cy(CW, sa(3), ~pat(sa(3)));
    cs = 3'h2;
    cy(CR, sa(3), '0);
    cy(IDLE, 19'h0, '0);
    chk("csc", dq_o, pat(sa(3)));
  endtask : t_csc
  task automatic t_sleep;
    @(posedge core_clk_i);
    sleep_req_i <= 1'h1;
    cy(CW, sa(2), ~pat(sa(2)));
    cy(IDLE, 19'h0, '0);
    chk("slp_oe", 36'(dq_oe_o), 36'h0);
    @(posedge core_clk_i);
    sleep_req_i <= 1'h0;
    cy(CR, sa(2), '0);
    cy(IDLE, 19'h0, '0);
    chk("slp", dq_o, pat(sa(2)));
  endtask : t_sleep
  task automatic t_lane;
    ssp_bus_t e;
    e = pat(sa(3));
    e[0] = ~e[0];
    e[2] = ~e[2];
    lw = 5'h0a;
    cy(CR, sa(3), ~pat(sa(3)));
    lw = 5'h1f;
    cy(CR, sa(3), '0);
    cy(IDLE, 19'h0, '0);
    chk("lane", dq_o, e);
  endtask : t_lane
  // Processor-strobe write: first clock ignores write pins, next clock writes
  task automatic t_pwr;
    cy(4'h6, sa(1), pat(sa(2)));
    cy(4'he, 19'h0, ~pat(sa(1)));
    chk("pw_first", dq_o, pat(sa(1)));
    cy(CR, sa(1), '0);
    chk("pw_thru", dq_o, ~pat(sa(1)));
    cy(IDLE, 19'h0, '0);
    chk("pw_arr", dq_o, ~pat(sa(1)));
  endtask : t_pwr
  task automatic t_oe;
    @(posedge core_clk_i);
    out_en_n_i <= 1'h1;
    #1;
    chk("oe_hi", 36'(dq_oe_o), 36'h0);
    @(posedge core_clk_i);
    out_en_n_i <= 1'h0;
    #1;
    chk("oe_lo", 36'(dq_oe_o), 36'h1);
  endtask : t_oe
  task automatic t_scan;
    @(posedge core_clk_i);
    tdi_i <= 1'h1;
    tck_i <= 1'h1;
    repeat (3) @(posedge core_clk_i);
    tdi_i <= 1'h0;
    tck_i <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("tdo", 36'(tdo_o), 36'h1);
  endtask : t_scan
  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Main sequence: interleaved run, then linear run
  initial begin
    t_reset(1'h1);
    t_burst();
    t_ign();
    t_both();
    t_csc();
    t_sleep();
    t_lane();
    t_pwr();
    t_oe();
    t_scan();
    t_reset(1'h0);
    t_burst();
    t_csc();
    wrap_up();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge core_clk_i);
    error_cnt++;
    wrap_up();
  end
endmodule : test_ssp_port
